//--- pkg/plmc_regs.vh
`ifndef PLMC_REGS_VH
`define PLMC_REGS_VH
`define PLMC_IDX_CTRL 3'h0
`define PLMC_IDX_PARTNER 3'h1
`define PLMC_IDX_EXPAN 3'h2
`define PLMC_IDX_STAT 3'h3
`define PLMC_IDX_CMD 3'h4
`define PLMC_CTRL_DUPLEX 8
`define PLMC_CTRL_RESTART 9
`define PLMC_CTRL_AN_EN 12
`define PLMC_CTRL_SPEED 13
`define PLMC_CTRL_RST 16'h3100
`define PLMC_EXP_PARTNER_AN 0
`define PLMC_EXP_PD_FAULT 4
`define PLMC_PTR_SELECTOR 5'h01
`define PLMC_PTR_10_HALF 5
`define PLMC_PTR_100_HALF 7
`define PLMC_STAT_LINK 0
`define PLMC_STAT_SPEED 1
`define PLMC_STAT_FULL 2
`define PLMC_STAT_HALT 3
`define PLMC_STAT_FORCED 4
`define PLMC_STAT_PARDET 5
`define PLMC_STAT_EV_LOST 16
`define PLMC_STAT_EV_PD 17
`define PLMC_STAT_EV_UP 18
`define PLMC_CMD_RESTART 0
`define PLMC_BREAK_MS 1200
`define PLMC_CLK_MHZ 100
`define PLMC_CYC_PER_MS (`PLMC_CLK_MHZ * 1000)
`endif

//--- verilog/plmc_break_timer.v
`timescale 1ns/100ps
module plmc_break_timer #(
	parameter CYC_PER_MS = 100000,
	parameter BREAK_MS   = 1200
) (
	input  wire i_clk_sys,
	input  wire i_nrst,
	input  wire i_start,
	output wire o_busy,
	output reg  o_done
);
	localparam DW = $clog2(CYC_PER_MS + 1);
	localparam MW = $clog2(BREAK_MS + 1);
	localparam integer  DIV_LAST_I = CYC_PER_MS - 1;
	localparam integer  MS_LAST_I  = BREAK_MS - 1;
	localparam [DW-1:0] DIV_LAST   = DIV_LAST_I[DW-1:0];
	localparam [MW-1:0] MS_LAST    = MS_LAST_I[MW-1:0];

	reg [DW-1:0] div_reg;
	reg [MW-1:0] ms_reg;
	reg          busy_reg;
	wire         ms_tick;

	// The millisecond enable restarts with every start so the wait is never short.
	assign ms_tick = busy_reg && (div_reg == DIV_LAST);
	assign o_busy  = busy_reg;

	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			div_reg  <= {DW{1'b0}};
			ms_reg   <= {MW{1'b0}};
			busy_reg <= 1'b0;
			o_done   <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin
				div_reg  <= {DW{1'b0}};
				ms_reg   <= {MW{1'b0}};
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (ms_tick) begin
					div_reg <= {DW{1'b0}};
					if (ms_reg == MS_LAST) begin
						busy_reg <= 1'b0;
						o_done   <= 1'b1;
					end else begin
						ms_reg <= ms_reg + 1'b1;
					end
				end else begin
					div_reg <= div_reg + 1'b1;
				end
			end
		end
	end
endmodule

//--- verilog/plmc_link_ctrl.v
`timescale 1ns/100ps
`include "plmc_regs.vh"
// Overview of operation
// (R01) No FLPs: speed from MLT-3 or NLPs
// (R02) Parallel-detected link runs half duplex
// (R03) Parallel detect clears partner-negotiates bit
// (R04) Parallel detect fault sets fault bit
// (R05) Partner ability register holds FLP word
// (R06) Parallel detect writes partner speed ability
// (R07) Writing restart bit restarts negotiation
// (R08) Signal loss restarts negotiation
// (R09) Commanded restart halts, waits break timer
// (R10) Clearing enable bit disables negotiation
// (R11) Disabled: speed, duplex forced from control
// (R12) Enabled: forced speed, duplex ignored
// (R13) Half duplex: carrier follows tx and rx
// (R14) Half duplex: rx during tx is collision
// (R15) Full duplex: carrier from rx, no collision
// (R16) Full duplex transmit keeps carrier low
// (R17) Active carrier high while line busy
// (R18) Read-only registers ignore writes
// (R19) Write-only register reads zero
// (R20) Write one clears, zero keeps
// (R21) Clear-on-read bit clears when read
// (R22) 32-bit words as two 16-bit accesses
module plmc_link_ctrl #(
	parameter CYC_PER_MS = `PLMC_CYC_PER_MS,
	parameter BREAK_MS   = `PLMC_BREAK_MS
) (
	input  wire        i_clk_sys,
	input  wire        i_nrst,
	input  wire [3:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [15:0] i_avs_writedata,
	input  wire [1:0]  i_avs_byteenable,
	output wire        o_avs_waitrequest,
	output reg  [15:0] o_avs_readdata,
	input  wire        i_flp_seen,
	input  wire [15:0] i_flp_word,
	input  wire        i_an_done,
	input  wire        i_an_speed100,
	input  wire        i_an_full,
	input  wire        i_mlt3_seen,
	input  wire        i_nlp_seen,
	input  wire        i_signal_ok,
	input  wire        i_rx_active,
	input  wire        i_tx_active,
	output reg         o_an_start,
	output wire        o_txrx_halt,
	output reg         o_link_up,
	output reg         o_speed100,
	output reg         o_full_duplex,
	output reg         o_crs,
	output reg         o_col
);
	localparam [3:0] ST_BREAK  = 4'h1;
	localparam [3:0] ST_NEG    = 4'h2;
	localparam [3:0] ST_LINK   = 4'h4;
	localparam [3:0] ST_FORCED = 4'h8;

	function hit;
		input [3:0] addr;
		input [2:0] idx;
		begin
			hit = (addr[3:1] == idx);
		end
	endfunction

	// Line-side inputs arrive from the analog front end and are resynchronised.
	reg  [23:0] sync1_reg;
	reg  [23:0] sync2_reg;
	wire        s_flp;
	wire        s_an_done;
	wire        s_an_100;
	wire        s_an_full;
	wire        s_mlt3;
	wire        s_nlp;
	wire        s_sig;
	wire        s_rx;
	wire [15:0] s_word;

	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			sync1_reg <= 24'h000000;
			sync2_reg <= 24'h000000;
		end else begin
			sync1_reg <= {i_flp_word, i_flp_seen, i_an_done, i_an_speed100, i_an_full,
				i_mlt3_seen, i_nlp_seen, i_signal_ok, i_rx_active};
			sync2_reg <= sync1_reg;
		end
	end

	assign s_word    = sync2_reg[23:8];
	assign s_flp     = sync2_reg[7];
	assign s_an_done = sync2_reg[6];
	assign s_an_100  = sync2_reg[5];
	assign s_an_full = sync2_reg[4];
	assign s_mlt3    = sync2_reg[3];
	assign s_nlp     = sync2_reg[2];
	assign s_sig     = sync2_reg[1];
	assign s_rx      = sync2_reg[0];

	reg         ack_reg;
	reg  [15:0] rd_hold_reg;
	reg  [15:0] wr_lo_reg;
	reg  [15:0] ctrl_reg;
	reg  [15:0] partner_reg;
	reg         partner_an_reg;
	reg         pd_fault_reg;
	reg         pardet_reg;
	reg         ev_lost_reg;
	reg         ev_pd_reg;
	reg         ev_up_reg;
	reg  [3:0]  st_reg;
	reg  [3:0]  st_next;
	reg  [31:0] rd_word;
	reg  [15:0] wr_merge;
	wire        req;
	wire        accept;
	wire        commit;
	wire [31:0] wr_word;
	wire        an_en;
	wire        restart_req;
	wire        timer_done;
	wire        ctrl_wr;
	wire        stat_wr;
	wire        exp_rd;

	// One wait cycle per access: read data are registered while waitrequest is high.
	assign req               = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_reg;
	assign accept            = req & ack_reg;

	always @* begin
		wr_merge = wr_lo_reg;
		if (i_avs_byteenable[0])
			wr_merge[7:0] = i_avs_writedata[7:0];
		if (i_avs_byteenable[1])
			wr_merge[15:8] = i_avs_writedata[15:8];
	end

	// (R22) high half commits word
	assign commit  = accept & i_avs_write & i_avs_address[0];
	assign wr_word = {wr_merge, wr_lo_reg};
	assign ctrl_wr = commit & hit(i_avs_address, `PLMC_IDX_CTRL);
	assign stat_wr = commit & hit(i_avs_address, `PLMC_IDX_STAT);
	assign exp_rd  = accept & i_avs_read & ~i_avs_address[0] & hit(i_avs_address, `PLMC_IDX_EXPAN);
	assign an_en   = ctrl_reg[`PLMC_CTRL_AN_EN];

	// (R07) restart on command write
	assign restart_req = ((ctrl_wr & wr_word[`PLMC_CTRL_RESTART])
		| (commit & hit(i_avs_address, `PLMC_IDX_CMD) & wr_word[`PLMC_CMD_RESTART]))
		& (ctrl_wr ? wr_word[`PLMC_CTRL_AN_EN] : an_en);

	// (R19) command register reads zero
	always @* begin
		rd_word = 32'h00000000;
		if (hit(i_avs_address, `PLMC_IDX_CTRL))
			rd_word[15:0] = ctrl_reg;
		else if (hit(i_avs_address, `PLMC_IDX_PARTNER))
			rd_word[15:0] = partner_reg;
		else if (hit(i_avs_address, `PLMC_IDX_EXPAN)) begin
			rd_word[`PLMC_EXP_PARTNER_AN] = partner_an_reg;
			rd_word[`PLMC_EXP_PD_FAULT]   = pd_fault_reg;
		end else if (hit(i_avs_address, `PLMC_IDX_STAT)) begin
			rd_word[`PLMC_STAT_LINK]    = o_link_up;
			rd_word[`PLMC_STAT_SPEED]   = o_speed100;
			rd_word[`PLMC_STAT_FULL]    = o_full_duplex;
			rd_word[`PLMC_STAT_HALT]    = st_reg[0];
			rd_word[`PLMC_STAT_FORCED]  = st_reg[3];
			rd_word[`PLMC_STAT_PARDET]  = pardet_reg;
			rd_word[`PLMC_STAT_EV_LOST] = ev_lost_reg;
			rd_word[`PLMC_STAT_EV_PD]   = ev_pd_reg;
			rd_word[`PLMC_STAT_EV_UP]   = ev_up_reg;
		end
	end

	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ack_reg        <= 1'b0;
			o_avs_readdata <= 16'h0000;
			rd_hold_reg    <= 16'h0000;
			wr_lo_reg      <= 16'h0000;
			ctrl_reg       <= `PLMC_CTRL_RST;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req & ~ack_reg & i_avs_read) begin
				// (R22) low half snapshots word
				if (!i_avs_address[0]) begin
					o_avs_readdata <= rd_word[15:0];
					rd_hold_reg    <= rd_word[31:16];
				end else begin
					o_avs_readdata <= rd_hold_reg;
				end
			end
			if (accept & i_avs_write & ~i_avs_address[0])
				wr_lo_reg <= wr_merge;
			// (R18) only control holds written data
			if (ctrl_wr) begin
				ctrl_reg <= wr_word[15:0];
				ctrl_reg[`PLMC_CTRL_RESTART] <= 1'b0;
			end
		end
	end

	plmc_break_timer #(
		.CYC_PER_MS(CYC_PER_MS),
		.BREAK_MS  (BREAK_MS)
	) u_break_timer (
		.i_clk_sys(i_clk_sys),
		.i_nrst   (i_nrst),
		.i_start  (restart_req),
		.o_busy   (),
		.o_done   (timer_done)
	);

	always @* begin
		st_next = st_reg;
		case (st_reg)
			ST_BREAK: begin
				if (!an_en)
					st_next = ST_FORCED;
				else if (timer_done)
					st_next = ST_NEG;
			end
			ST_NEG: begin
				// (R10) disable leaves negotiation
				if (!an_en)
					st_next = ST_FORCED;
				else if (s_flp & s_an_done)
					st_next = ST_LINK;
				else if (!s_flp & (s_mlt3 ^ s_nlp))
					st_next = ST_LINK;
			end
			ST_LINK: begin
				if (!an_en)
					st_next = ST_FORCED;
				else if (!s_sig)
					st_next = ST_NEG;
			end
			ST_FORCED: begin
				if (an_en)
					st_next = ST_NEG;
			end
			default: st_next = ST_NEG;
		endcase
		// (R09) commanded restart waits
		if (restart_req)
			st_next = ST_BREAK;
	end

	// (R09) halt traffic during break
	assign o_txrx_halt = st_reg[0];

	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg         <= ST_NEG;
			o_an_start     <= 1'b1;
			o_link_up      <= 1'b0;
			o_speed100     <= 1'b0;
			o_full_duplex  <= 1'b0;
			partner_reg    <= 16'h0000;
			partner_an_reg <= 1'b0;
			pardet_reg     <= 1'b0;
		end else begin
			st_reg     <= st_next;
			o_an_start <= 1'b0;
			// (R08) loss restarts negotiation
			if (st_next == ST_NEG && st_reg != ST_NEG)
				o_an_start <= 1'b1;
			if (st_next != ST_LINK && st_next != ST_FORCED)
				o_link_up <= 1'b0;
			// (R12) control speed, duplex unused
			if (st_reg == ST_NEG && st_next == ST_LINK) begin
				o_link_up <= 1'b1;
				if (s_flp) begin
					// (R05) store partner code word
					partner_reg    <= s_word;
					partner_an_reg <= 1'b1;
					pardet_reg     <= 1'b0;
					o_speed100     <= s_an_100;
					o_full_duplex  <= s_an_full;
				end else begin
					// (R01) speed from idle signalling
					o_speed100     <= s_mlt3;
					// (R02) half duplex assumed
					o_full_duplex  <= 1'b0;
					// (R03) partner cannot negotiate
					partner_an_reg <= 1'b0;
					pardet_reg     <= 1'b1;
					// (R06) partner speed ability
					partner_reg <= 16'h0000;
					partner_reg[4:0] <= `PLMC_PTR_SELECTOR;
					if (s_mlt3)
						partner_reg[`PLMC_PTR_100_HALF] <= 1'b1;
					else
						partner_reg[`PLMC_PTR_10_HALF] <= 1'b1;
				end
			end
			// (R11) forced speed and duplex
			if (st_next == ST_FORCED) begin
				o_link_up     <= s_sig;
				o_speed100    <= ctrl_reg[`PLMC_CTRL_SPEED];
				o_full_duplex <= ctrl_reg[`PLMC_CTRL_DUPLEX];
				pardet_reg    <= 1'b0;
			end
		end
	end

	// Status events and the fault flag: a new event always beats a clear.
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			pd_fault_reg <= 1'b0;
			ev_lost_reg  <= 1'b0;
			ev_pd_reg    <= 1'b0;
			ev_up_reg    <= 1'b0;
		end else begin
			// (R21) cleared by reading
			if (exp_rd)
				pd_fault_reg <= 1'b0;
			// (R04) both signallings seen
			if (st_reg == ST_NEG && an_en && !s_flp && s_mlt3 && s_nlp)
				pd_fault_reg <= 1'b1;
			// (R20) write one clears
			if (stat_wr) begin
				if (wr_word[`PLMC_STAT_EV_LOST])
					ev_lost_reg <= 1'b0;
				if (wr_word[`PLMC_STAT_EV_PD])
					ev_pd_reg <= 1'b0;
				if (wr_word[`PLMC_STAT_EV_UP])
					ev_up_reg <= 1'b0;
			end
			if (st_reg == ST_LINK && st_next == ST_NEG)
				ev_lost_reg <= 1'b1;
			if (st_reg == ST_NEG && st_next == ST_LINK) begin
				ev_up_reg <= 1'b1;
				if (!s_flp)
					ev_pd_reg <= 1'b1;
			end
		end
	end

	// Carrier and collision are registered, so they lag transmit activity by one cycle and receive activity by three.
	always @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_crs <= 1'b0;
			o_col <= 1'b0;
		end else if (!o_link_up || st_reg[0]) begin
			o_crs <= 1'b0;
			o_col <= 1'b0;
		end else if (o_full_duplex) begin
			// (R15) receive only, no collision
			// (R16) transmit keeps carrier low
			o_crs <= s_rx;
			o_col <= 1'b0;
		end else begin
			// (R13) both directions sensed
			// (R17) high while line busy
			o_crs <= s_rx | i_tx_active;
			// (R14) receive during transmit
			o_col <= s_rx & i_tx_active;
		end
	end
endmodule

//--- bench/plmc_partner.sv
`timescale 1ns/100ps
module plmc_partner #(
	parameter        AN_DLY = 5,
	parameter [15:0] WORD   = 16'h01E1
) (
	input  wire        i_clk_sys,
	input  wire [2:0]  i_mode,
	input  wire        i_rx_on,
	output reg         o_flp_seen,
	output reg  [15:0] o_flp_word,
	output reg         o_an_done,
	output reg         o_an_speed100,
	output reg         o_an_full,
	output reg         o_mlt3_seen,
	output reg         o_nlp_seen,
	output reg         o_signal_ok,
	output reg         o_rx_active
);
	reg [3:0] cnt_reg;
	initial begin
		{o_flp_seen, o_an_done, o_an_speed100, o_an_full, o_mlt3_seen} = 5'h00;
		{o_nlp_seen, o_signal_ok, o_rx_active} = 3'h0;
		o_flp_word = 16'h0000;
		cnt_reg = 4'h0;
	end
	// Modes: 0 silent, 1 negotiating, 2 legacy 100M, 3 legacy 10M, 4 both legacy kinds.
	always @(posedge i_clk_sys) begin
		o_signal_ok <= i_mode != 3'h0;
		o_rx_active <= i_rx_on && i_mode != 3'h0;
		o_flp_seen <= i_mode == 3'h1;
		o_mlt3_seen <= i_mode == 3'h2 || i_mode == 3'h4;
		o_nlp_seen <= i_mode == 3'h3 || i_mode == 3'h4;
		// Released lines show a changing pattern so a stale value is never mistaken for data.
		o_flp_word <= (i_mode == 3'h1) ? WORD : ~o_flp_word;
		cnt_reg <= (i_mode != 3'h1) ? 4'h0 : (cnt_reg == AN_DLY) ? cnt_reg : cnt_reg + 4'h1;
		o_an_done <= i_mode == 3'h1 && cnt_reg == AN_DLY;
		o_an_speed100 <= (i_mode == 3'h1) ? 1'b1 : ~o_an_speed100;
		o_an_full <= (i_mode == 3'h1) ? 1'b1 : ~o_an_full;
	end
endmodule

//--- bench/plmc_link_ctrl_assertions.sv
`timescale 1ns/100ps
module plmc_chk (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire i_signal_ok,
	input wire i_rx_active,
	input wire i_tx_active,
	input wire o_avs_waitrequest,
	input wire o_an_start,
	input wire o_txrx_halt,
	input wire o_link_up,
	input wire o_full_duplex,
	input wire o_crs,
	input wire o_col
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	chk_bus_wait: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("wait state longer than one cycle");
	chk_start_pulse: assert property (
		o_an_start |=> !o_an_start) else $error("start not a single pulse");
	chk_link_drop: assert property (
		o_link_up && $fell(i_signal_ok) |-> ##[1:6] !o_link_up)
		else $error("link kept after signal loss");
	chk_halt_quiet: assert property (
		o_txrx_halt && $past(o_txrx_halt) |-> !o_crs && !o_col)
		else $error("activity during break wait");
	chk_halt_then_start: assert property (
		$fell(o_txrx_halt) |-> ##[0:2] o_an_start) else $error("no start after break wait");
	chk_full_nocol: assert property (
		o_full_duplex && $past(o_full_duplex) |-> !o_col) else $error("collision in full duplex");
	chk_half_col: assert property (
		(o_link_up && !o_full_duplex && !o_txrx_halt && i_rx_active && i_tx_active)[*5]
		|-> o_col) else $error("no collision in half duplex");
	chk_full_tx_crs: assert property (
		(o_link_up && o_full_duplex && !o_txrx_halt && !i_rx_active)[*5] |-> !o_crs)
		else $error("carrier from transmit in full duplex");
	chk_crs_rx: assert property (
		(o_link_up && !o_txrx_halt && i_rx_active)[*5] |-> o_crs)
		else $error("no carrier while receiving");
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
	reg         clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, tx = 1'b0, rxon = 1'b0;
	reg  [3:0]  adr = 4'h0;
	reg  [15:0] wd = 16'h0000;
	reg  [2:0]  mode = 3'h0;
	wire        wreq, ast, halt, link, spd, full, crs, col;
	wire        flp, andone, asp, afu, mlt, nlp, sok, rxa;
	wire [15:0] rdata, word;
	integer     fail_count = 0, checked = 0, n, k;
	reg  [31:0] q;
	always #5 clk = ~clk;
	plmc_partner plmc_partner_i (.i_clk_sys(clk), .i_mode(mode), .i_rx_on(rxon),
		.o_flp_seen(flp), .o_flp_word(word), .o_an_done(andone), .o_an_speed100(asp),
		.o_an_full(afu), .o_mlt3_seen(mlt), .o_nlp_seen(nlp), .o_signal_ok(sok),
		.o_rx_active(rxa));
	plmc_link_ctrl #(.CYC_PER_MS(4), .BREAK_MS(3)) plmc_link_ctrl_i (.i_clk_sys(clk),
		.i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(2'h3), .o_avs_waitrequest(wreq),
		.o_avs_readdata(rdata), .i_flp_seen(flp), .i_flp_word(word), .i_an_done(andone),
		.i_an_speed100(asp), .i_an_full(afu), .i_mlt3_seen(mlt), .i_nlp_seen(nlp),
		.i_signal_ok(sok), .i_rx_active(rxa), .i_tx_active(tx), .o_an_start(ast),
		.o_txrx_halt(halt), .o_link_up(link), .o_speed100(spd), .o_full_duplex(full),
		.o_crs(crs), .o_col(col));
	task conclude;
		begin
			$display("checked=%0d fail_count=%0d", checked, fail_count);
			if (fail_count == 0 && checked > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task tmo;
		begin
			fail_count = fail_count + 1;
			$display("MISMATCH at %0t: wait ran out", $time);
			conclude;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			checked = checked + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// Waitrequest and read data are read right at the rising edge, before it updates them.
	task bus(input w, input [3:0] a, input [15:0] d, output [15:0] r);
		begin
			rd <= !w;
			wr <= w;
			adr <= a;
			wd <= d;
			n = 0;
			@(posedge clk);
			while (wreq !== 1'b0 && n < 50) begin
				n = n + 1;
				@(posedge clk);
			end
			if (n >= 50)
				tmo;
			r = rdata;
			rd <= 1'b0;
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd32(input [2:0] i, output [31:0] v);
		reg [15:0] lo, hi;
		begin
			bus(1'b0, {i, 1'b0}, 16'h0000, lo);
			bus(1'b0, {i, 1'b1}, 16'h0000, hi);
			v = {hi, lo};
		end
	endtask
	task wr32(input [2:0] i, input [31:0] v);
		reg [15:0] t;
		begin
			bus(1'b1, {i, 1'b0}, v[15:0], t);
			bus(1'b1, {i, 1'b1}, v[31:16], t);
		end
	endtask
	task wlink(input v);
		begin
			n = 0;
			while (link !== v && n < 200) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n >= 200)
				tmo;
		end
	endtask
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd32(3'h0, q); chk(q[15:0], 32'h3100);
		bus(1'b1, 4'h0, 16'h0000, q[15:0]);
		rd32(3'h0, q); chk(q[15:0], 32'h3100);
		rd32(3'h4, q); chk(q, 32'h0);
		wr32(3'h5, 32'hFFFF_FFFF); rd32(3'h5, q); chk(q, 32'h0);
		$display("test reset values finished");
		mode <= 3'h1;
		wlink(1'b1);
		rd32(3'h1, q); chk(q[15:0], 32'h01E1);
		wr32(3'h1, 32'h0); rd32(3'h1, q); chk(q[15:0], 32'h01E1);
		rd32(3'h2, q); chk(q[0], 32'h1);
		rd32(3'h3, q); chk(q[18], 32'h1);
		wr32(3'h3, 32'h0004_0000); rd32(3'h3, q); chk(q[18], 32'h0);
		tx <= 1'b1; repeat (6) @(posedge clk); chk({crs, col}, 32'h0);
		rxon <= 1'b1; repeat (6) @(posedge clk); chk({crs, col, full}, 32'h5);
		tx <= 1'b0;
		mode <= 3'h0;
		wlink(1'b0);
		rd32(3'h3, q); chk(q[16], 32'h1);
		wr32(3'h3, 32'h0); rd32(3'h3, q); chk(q[16], 32'h1);
		$display("test negotiated link finished");
		for (k = 0; k < 2; k = k + 1) begin
			mode <= k ? 3'h3 : 3'h2;
			rxon <= 1'b0;
			wlink(1'b1);
			chk({spd, full}, {k == 0, 1'b0});
			rd32(3'h2, q); chk(q[0], 32'h0);
			rd32(3'h1, q); chk(q[15:0], k ? 32'h0021 : 32'h0081);
			rd32(3'h3, q); chk({q[17], q[5]}, 32'h3);
			tx <= 1'b1; repeat (6) @(posedge clk); chk({crs, col}, 32'h2);
			rxon <= 1'b1; repeat (6) @(posedge clk); chk({crs, col}, 32'h3);
			tx <= 1'b0;
			mode <= 3'h0;
			wlink(1'b0);
		end
		$display("test parallel detection finished");
		mode <= 3'h4;
		repeat (10) @(posedge clk);
		rd32(3'h2, q); chk(q[4], 32'h1);
		mode <= 3'h0;
		repeat (10) @(posedge clk);
		rd32(3'h2, q); chk(q[4], 32'h1);
		rd32(3'h2, q); chk(q[4], 32'h0);
		$display("test fault finished");
		mode <= 3'h1;
		wlink(1'b1);
		wr32(3'h0, 32'h0000_3300);
		n = 0;
		while (halt !== 1'b1 && n < 10) begin
			@(posedge clk);
			n = n + 1;
		end
		k = 0;
		while (halt === 1'b1 && k < 100) begin
			@(posedge clk);
			k = k + 1;
		end
		chk(k >= 12 && k <= 16, 32'h1);
		chk(ast, 32'h1);
		rd32(3'h0, q); chk(q[9], 32'h0);
		wlink(1'b1);
		wr32(3'h4, 32'h0000_0001); chk(halt, 32'h1);
		wlink(1'b1);
		$display("test restart finished");
		for (k = 0; k < 4; k = k + 1) begin
			wr32(3'h0, {18'h00000, k[1], 4'h0, k[0], 8'h00});
			repeat (4) @(posedge clk);
			chk({link, spd, full}, {1'b1, k[1], k[0]});
		end
		rd32(3'h3, q); chk(q[4], 32'h1);
		$display("test forced modes finished");
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd32(3'h0, q); chk(q[15:0], 32'h3100);
		wlink(1'b1); chk({spd, full}, 32'h3);
		$display("test second reset finished");
		conclude;
	end
endmodule
bind plmc_link_ctrl plmc_chk plmc_chk_i (.i_clk_sys, .i_nrst, .i_avs_read, .i_avs_write,
	.i_signal_ok, .i_rx_active, .i_tx_active, .o_avs_waitrequest, .o_an_start,
	.o_txrx_halt, .o_link_up, .o_full_duplex, .o_crs, .o_col);
